// file: rail_sequencer.sv
// Rail sequencing, group event handling and overcurrent response
//
// What this block does
// - Output turns on only when enabled and the preceding rail reported power good.
// - Output turns off, after its turn-off delay, when following rail reports power down.
// - Rail order bits 12:8 hold the preceding rail identifier, 0 to 31.
// - Rail order bits 4:0 hold the following rail identifier, 0 to 31.
// - Rail order bit 15 enables waiting on a preceding rail.
// - Rail order bit 7 enables reacting to a following rail.
// - Group bits 4:0 are the fault group, sent with our power-fail events.
// - Group bits 12:8 are the operation group, sent with broadcast operation events.
// - Group bits 20:16 are the voltage group; bit 21 enables acting on matches.
// - Group bit 13 enables acting on operation events with our group.
// - Matching power-fail: bit 5 low sequenced shutdown, high immediate shutdown.
// - Current-sharing rails spread power-fail responses regardless of group settings.
// - Identifier is read-only; a read returns a 16-character ASCII string.
// - Overcurrent mode 10 turns off then retries; 11 turns off and resumes.
// - Every overcurrent response drives the alert line low and sets the status bit.
// - Bits 5:3 give the number of restart attempts after overcurrent shutdown.
// - Retry count 000 stays off until cleared; 111 retries without limit.
// - Restart interval is field bits 2:0 plus one, times 35 ms.
`default_nettype none
module rail_sequencer #(
    parameter int RETRY_STEP_CYCLES = rail_seq_pkg::RETRY_STEP_CYCLES,
    // Arbitrary neutral identifier string
    parameter logic [127:0] IDENT_STRING = "RAIL-SEQ-CORE-01"
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire rail_seq_pkg::mgmt_cmd_t cmd,
    output rail_seq_pkg::mgmt_rsp_t rsp,
    input wire logic enable_state,
    input wire logic [4:0] own_rail_id,
    input wire logic [15:0] turn_off_delay,
    input wire logic current_share_on,
    input wire logic oc_fault,
    input wire logic clear_faults,
    input wire logic bcast_operation_req,
    input wire logic bcast_vout_req,
    input wire rail_seq_pkg::gbus_evt_t gbus_in,
    output rail_seq_pkg::gbus_evt_t gbus_out,
    output logic rail_on,
    output logic alert_line_n,
    output logic oc_status,
    output logic operation_hit,
    output logic vout_hit
);
    typedef enum logic [2:0] {
        S_OFF, S_WAIT_PRE, S_ON, S_SEQ_OFF, S_RETRY_WAIT, S_RESUME_WAIT, S_FAULT_HOLD
    } seq_state_t;

    // Configuration registers
    logic [15:0] rail_order_setup, next_rail_order_setup;
    logic [31:0] rail_group_setup, next_rail_group_setup;
    logic [7:0] overcurrent_fault_action, next_overcurrent_fault_action;

    rail_seq_pkg::mgmt_rsp_t next_rsp;

    always_comb begin
        next_rail_order_setup = rail_order_setup;
        next_rail_group_setup = rail_group_setup;
        next_overcurrent_fault_action = overcurrent_fault_action;

        next_rsp = '0;

        if (cmd.valid) begin
            next_rsp.valid = 1'b1;
            unique case (cmd.code)
                rail_seq_pkg::CODE_RAIL_ORDER: begin
                    if (cmd.write) next_rail_order_setup = cmd.data[15:0];
                    next_rsp.data = {112'h0, rail_order_setup};
                end

                rail_seq_pkg::CODE_GROUP: begin
                    if (cmd.write) next_rail_group_setup = cmd.data;
                    next_rsp.data = {96'h0, rail_group_setup};
                end

                rail_seq_pkg::CODE_IDENT: begin
                    // Writes refused, string is fixed
                    next_rsp.error = cmd.write;
                    next_rsp.data = cmd.write ? 128'h0 : IDENT_STRING;
                end

                rail_seq_pkg::CODE_OC_ACTION: begin
                    if (cmd.write) next_overcurrent_fault_action = cmd.data[7:0];
                    next_rsp.data = {120'h0, overcurrent_fault_action};
                end

                default: next_rsp.error = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rail_order_setup <= rail_seq_pkg::RAIL_ORDER_RESET;
            rail_group_setup <= rail_seq_pkg::GROUP_RESET;
            overcurrent_fault_action <= rail_seq_pkg::OC_ACTION_RESET;
            rsp <= '0;
        end else begin
            rail_order_setup <= next_rail_order_setup;
            rail_group_setup <= next_rail_group_setup;
            overcurrent_fault_action <= next_overcurrent_fault_action;
            rsp <= next_rsp;
        end
    end

    // Field views
    logic pre_en, fol_en, fault_immed, op_en, vout_en;
    logic [4:0] pre_id, fol_id, fault_gid, op_gid, vout_gid;
    logic [1:0] oc_mode;
    logic [2:0] retry_limit, retry_time;

    assign pre_en = rail_order_setup[rail_seq_pkg::PRE_EN_BIT];
    assign pre_id = rail_order_setup[rail_seq_pkg::PRE_ID_LSB +: 5];
    assign fol_en = rail_order_setup[rail_seq_pkg::FOL_EN_BIT];
    assign fol_id = rail_order_setup[rail_seq_pkg::FOL_ID_LSB +: 5];

    assign fault_gid = rail_group_setup[rail_seq_pkg::FAULT_GID_LSB +: 5];
    assign fault_immed = rail_group_setup[rail_seq_pkg::FAULT_IMMED_BIT];

    assign op_gid = rail_group_setup[rail_seq_pkg::OP_GID_LSB +: 5];
    assign op_en = rail_group_setup[rail_seq_pkg::OP_EN_BIT];

    assign vout_gid = rail_group_setup[rail_seq_pkg::VOUT_GID_LSB +: 5];
    assign vout_en = rail_group_setup[rail_seq_pkg::VOUT_EN_BIT];

    assign oc_mode = overcurrent_fault_action[rail_seq_pkg::OC_MODE_LSB +: 2];
    assign retry_limit = overcurrent_fault_action[rail_seq_pkg::OC_RETRY_LSB +: 3];
    assign retry_time = overcurrent_fault_action[rail_seq_pkg::OC_TIME_LSB +: 3];

    // Received event decode
    logic pre_good_evt, pre_down_evt, fol_down_evt, fail_evt;
    assign pre_good_evt = gbus_in.valid && gbus_in.kind == rail_seq_pkg::EVT_POWER_GOOD
        && gbus_in.id == pre_id;

    assign pre_down_evt = gbus_in.valid && gbus_in.kind == rail_seq_pkg::EVT_POWER_DOWN
        && gbus_in.id == pre_id;

    assign fol_down_evt = fol_en && gbus_in.valid
        && gbus_in.kind == rail_seq_pkg::EVT_POWER_DOWN && gbus_in.id == fol_id;

    assign fail_evt = gbus_in.valid && ((gbus_in.kind == rail_seq_pkg::EVT_POWER_FAIL
        && gbus_in.id == fault_gid)
        || (current_share_on && gbus_in.kind == rail_seq_pkg::EVT_SHARE_FAIL));

    // Sequencer state
    seq_state_t state, next_state;

    logic pre_seen, next_pre_seen;
    logic [15:0] off_cnt, next_off_cnt;
    logic [2:0] attempts, next_attempts;
    logic next_rail_on, next_oc_status, next_alert_line_n;
    logic next_operation_hit, next_vout_hit;
    rail_seq_pkg::gbus_evt_t next_gbus_out;
    logic timer_start, timer_done;

    retry_interval_timer #(
        .UNIT_CYCLES(RETRY_STEP_CYCLES)
    ) retry_interval_timer_i (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(timer_start),
        .abort(next_state != S_RETRY_WAIT),
        .steps(retry_time),
        .done(timer_done)
    );

    always_comb begin
        logic fault_entry;
        fault_entry = 1'b0;
        next_state = state;
        next_off_cnt = off_cnt;
        next_attempts = attempts;

        timer_start = 1'b0;
        next_gbus_out = '0;

        // Hold predecessor status until it reports power down
        next_pre_seen = pre_good_evt ? 1'b1 : (pre_down_evt ? 1'b0 : pre_seen);

        // A new fault outranks a clear in the same cycle
        next_oc_status = (oc_status && !clear_faults) || (oc_fault && rail_on);
        unique case (state)
            S_OFF: begin
                next_attempts = 3'h0;
                if (enable_state) next_state = S_WAIT_PRE;
            end

            S_WAIT_PRE: begin
                if (!enable_state || fail_evt) begin
                    next_state = S_OFF;
                end else if (!pre_en || pre_seen) begin
                    next_state = S_ON;
                    next_gbus_out = '{1'b1, rail_seq_pkg::EVT_POWER_GOOD, own_rail_id};
                end
            end

            S_ON: begin
                // Fault outranks other exits
                if (oc_fault) begin
                    fault_entry = 1'b1;
                end else if (fail_evt && fault_immed) begin
                    next_state = S_OFF;
                    next_gbus_out = '{1'b1, rail_seq_pkg::EVT_POWER_DOWN, own_rail_id};
                end else if (fail_evt || !enable_state || fol_down_evt) begin
                    next_state = S_SEQ_OFF;
                    next_off_cnt = 16'h0;
                end
            end

            S_SEQ_OFF: begin
                if (oc_fault) begin
                    fault_entry = 1'b1;
                end else if (off_cnt >= turn_off_delay || (fail_evt && fault_immed)) begin
                    next_state = S_OFF;
                    next_gbus_out = '{1'b1, rail_seq_pkg::EVT_POWER_DOWN, own_rail_id};
                end else begin
                    next_off_cnt = off_cnt + 16'h1;
                end
            end

            S_RETRY_WAIT: begin
                if (!enable_state) next_state = S_OFF;
                else if (timer_done) next_state = S_WAIT_PRE;
            end

            S_RESUME_WAIT: begin
                if (!enable_state) next_state = S_OFF;
                else if (!oc_fault) next_state = S_WAIT_PRE;
            end

            S_FAULT_HOLD: begin
                // Only a clear with the fault gone releases the rail
                if (clear_faults && !oc_fault) next_state = S_OFF;
            end
        endcase

        if (fault_entry) begin
            // Output off at once in every mode
            next_gbus_out = '{1'b1, current_share_on ? rail_seq_pkg::EVT_SHARE_FAIL
                : rail_seq_pkg::EVT_POWER_FAIL, fault_gid};
            if (oc_mode == rail_seq_pkg::OC_MODE_RESUME) begin
                next_state = S_RESUME_WAIT;
            end else if (retry_limit == rail_seq_pkg::RETRY_NONE
                || (retry_limit != rail_seq_pkg::RETRY_ENDLESS
                && attempts >= retry_limit)) begin
                next_state = S_FAULT_HOLD;
            end else begin
                next_state = S_RETRY_WAIT;
                timer_start = 1'b1;
                if (retry_limit != rail_seq_pkg::RETRY_ENDLESS) begin
                    next_attempts = attempts + 3'h1;
                end
            end
        end

        // Broadcasts only go out on an otherwise idle cycle
        if (!next_gbus_out.valid && bcast_operation_req) begin
            next_gbus_out = '{1'b1, rail_seq_pkg::EVT_OPERATION, op_gid};
        end else if (!next_gbus_out.valid && bcast_vout_req) begin
            next_gbus_out = '{1'b1, rail_seq_pkg::EVT_VOUT_COMMAND, vout_gid};
        end

        next_rail_on = next_state == S_ON || next_state == S_SEQ_OFF;
        next_alert_line_n = !next_oc_status;

        next_operation_hit = op_en && gbus_in.valid
            && gbus_in.kind == rail_seq_pkg::EVT_OPERATION && gbus_in.id == op_gid;
        next_vout_hit = vout_en && gbus_in.valid
            && gbus_in.kind == rail_seq_pkg::EVT_VOUT_COMMAND && gbus_in.id == vout_gid;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= S_OFF;
            pre_seen <= 1'b0;
            off_cnt <= 16'h0;
            attempts <= 3'h0;
            rail_on <= 1'b0;
            oc_status <= 1'b0;
            alert_line_n <= 1'b1;
            operation_hit <= 1'b0;
            vout_hit <= 1'b0;
            gbus_out <= '0;
        end else begin
            state <= next_state;
            pre_seen <= next_pre_seen;
            off_cnt <= next_off_cnt;
            attempts <= next_attempts;
            rail_on <= next_rail_on;
            oc_status <= next_oc_status;
            alert_line_n <= next_alert_line_n;
            operation_hit <= next_operation_hit;
            vout_hit <= next_vout_hit;
            gbus_out <= next_gbus_out;
        end
    end
endmodule
`default_nettype wire

// file: rail_seq_pkg.sv
// Shared constants, types and register map for the rail sequencing block
`default_nettype none
package rail_seq_pkg;
    // Management command codes
    localparam logic [7:0] CODE_RAIL_ORDER = 8'h00_E0;
    localparam logic [7:0] CODE_GROUP = 8'h00_E2;
    localparam logic [7:0] CODE_IDENT = 8'h00_E4;
    localparam logic [7:0] CODE_OC_ACTION = 8'h00_E5;

    // Reset values
    localparam logic [15:0] RAIL_ORDER_RESET = 16'h0000;
    localparam logic [31:0] GROUP_RESET = 32'h0000_0000;
    localparam logic [7:0] OC_ACTION_RESET = 8'h00_80;

    // Rail order word fields
    localparam int PRE_EN_BIT = 15;
    localparam int PRE_ID_LSB = 8;
    localparam int FOL_EN_BIT = 7;
    localparam int FOL_ID_LSB = 0;

    // Group word fields
    localparam int FAULT_GID_LSB = 0;
    localparam int FAULT_IMMED_BIT = 5;
    localparam int OP_GID_LSB = 8;
    localparam int OP_EN_BIT = 13;
    localparam int VOUT_GID_LSB = 16;
    localparam int VOUT_EN_BIT = 21;

    // Overcurrent action fields
    localparam int OC_MODE_LSB = 6;
    localparam int OC_RETRY_LSB = 3;
    localparam int OC_TIME_LSB = 0;
    localparam logic [1:0] OC_MODE_RETRY = 2'h2;
    localparam logic [1:0] OC_MODE_RESUME = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;

    // Retry timing
    localparam int CLK_KHZ = 50_000;
    localparam int RETRY_STEP_MS = 35;
    localparam int RETRY_STEP_CYCLES = RETRY_STEP_MS * CLK_KHZ;
    localparam int UNIT_W = 21;

    // Group bus event kinds
    typedef enum logic [2:0] {
        EVT_NONE = 3'h0,
        EVT_POWER_GOOD = 3'h1,
        EVT_POWER_DOWN = 3'h2,
        EVT_POWER_FAIL = 3'h3,
        EVT_OPERATION = 3'h4,
        EVT_VOUT_COMMAND = 3'h5,
        EVT_SHARE_FAIL = 3'h6
    } evt_kind_t;

    typedef struct packed {
        logic valid;
        evt_kind_t kind;
        logic [4:0] id;
    } gbus_evt_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [31:0] data;
    } mgmt_cmd_t;

    typedef struct packed {
        logic valid;
        logic error;
        logic [127:0] data;
    } mgmt_rsp_t;
endpackage
`default_nettype wire

// file: retry_interval_timer.sv
// Restart interval timer counting whole 35 ms steps
`default_nettype none
module retry_interval_timer #(
    parameter int UNIT_CYCLES = rail_seq_pkg::RETRY_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic abort,
    input wire logic [2:0] steps,
    output logic done
);
    logic busy, next_busy;
    logic [rail_seq_pkg::UNIT_W-1:0] unit_cnt, next_unit_cnt;
    logic [2:0] step_cnt, next_step_cnt;
    logic next_done;

    always_comb begin
        next_busy = busy;
        next_unit_cnt = unit_cnt;
        next_step_cnt = step_cnt;
        next_done = 1'b0;
        if (abort) begin
            next_busy = 1'b0;
        end else if (start) begin
            // Field value plus one steps
            next_busy = 1'b1;
            next_unit_cnt = '0;
            next_step_cnt = steps;
        end else if (busy) begin
            if (unit_cnt == rail_seq_pkg::UNIT_W'(UNIT_CYCLES - 1)) begin
                next_unit_cnt = '0;
                if (step_cnt == 3'h0) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                end else begin
                    next_step_cnt = step_cnt - 3'h1;
                end
            end else begin
                next_unit_cnt = unit_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            unit_cnt <= '0;
            step_cnt <= 3'h0;
            done <= 1'b0;
        end else begin
            busy <= next_busy;
            unit_cnt <= next_unit_cnt;
            step_cnt <= next_step_cnt;
            done <= next_done;
        end
    end
endmodule
`default_nettype wire

// file: rail_sequencer_sva.sv
// Concurrent checks on the rail sequencing block ports
`default_nettype none
module rail_sequencer_sva #(
    parameter int RETRY_STEP_CYCLES = 10,
    parameter logic [127:0] IDENT_STRING = "RAIL-SEQ-CORE-01"
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire rail_seq_pkg::mgmt_cmd_t cmd,
    input wire rail_seq_pkg::mgmt_rsp_t rsp,
    input wire logic enable_state,
    input wire logic [4:0] own_rail_id,
    input wire logic [15:0] turn_off_delay,
    input wire logic current_share_on,
    input wire logic oc_fault,
    input wire logic clear_faults,
    input wire logic bcast_operation_req,
    input wire logic bcast_vout_req,
    input wire rail_seq_pkg::gbus_evt_t gbus_in,
    input wire rail_seq_pkg::gbus_evt_t gbus_out,
    input wire logic rail_on,
    input wire logic alert_line_n,
    input wire logic oc_status,
    input wire logic operation_hit,
    input wire logic vout_hit
);
    logic [31:0] grp;
    logic [31:0] next_grp;
    logic op_match;
    logic vout_match;
    logic pf_imm;
    // Shadow of the group word, needed to judge event matches
    always_comb begin
        next_grp = grp;
        if (cmd.valid && cmd.write && cmd.code == rail_seq_pkg::CODE_GROUP) begin
            next_grp = cmd.data;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            grp <= rail_seq_pkg::GROUP_RESET;
        end else begin
            grp <= next_grp;
        end
    end
    assign op_match = grp[13] && gbus_in.id == grp[12:8];
    assign vout_match = grp[21] && gbus_in.id == grp[20:16];
    assign pf_imm = gbus_in.valid && gbus_in.kind == rail_seq_pkg::EVT_POWER_FAIL
        && gbus_in.id == grp[4:0] && grp[5] && rail_on && !oc_fault;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_good;
        gbus_out.valid && gbus_out.kind == rail_seq_pkg::EVT_POWER_GOOD
            && gbus_out.id == own_rail_id;
    endsequence
    sequence s_down;
        gbus_out.valid && gbus_out.kind == rail_seq_pkg::EVT_POWER_DOWN;
    endsequence
    sequence s_fail;
        gbus_out.valid && gbus_out.kind == (current_share_on ? rail_seq_pkg::EVT_SHARE_FAIL
            : rail_seq_pkg::EVT_POWER_FAIL);
    endsequence
    property p_ident;
        cmd.valid && !cmd.write && cmd.code == rail_seq_pkg::CODE_IDENT
            |=> rsp.valid && !rsp.error && rsp.data == IDENT_STRING;
    endproperty
    a_ident: assert property (p_ident) else $error("identifier read wrong");
    property p_on;
        $rose(rail_on) |-> s_good;
    endproperty
    a_on: assert property (p_on) else $error("turn-on without power-good event");
    property p_oc;
        rail_on && oc_fault |=> !rail_on && oc_status ##0 s_fail;
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent response wrong");
    property p_alert;
        alert_line_n == !oc_status;
    endproperty
    a_alert: assert property (p_alert) else $error("alert line not tied to status");
    property p_clear;
        $fell(oc_status) |-> $past(clear_faults) && !($past(oc_fault) && $past(rail_on));
    endproperty
    a_clear: assert property (p_clear) else $error("status dropped without clear");
    property p_op;
        gbus_in.valid && gbus_in.kind == rail_seq_pkg::EVT_OPERATION
            |=> operation_hit == $past(op_match);
    endproperty
    a_op: assert property (p_op) else $error("operation match wrong");
    property p_vout;
        gbus_in.valid && gbus_in.kind == rail_seq_pkg::EVT_VOUT_COMMAND
            |=> vout_hit == $past(vout_match);
    endproperty
    a_vout: assert property (p_vout) else $error("voltage command match wrong");
    property p_imm;
        pf_imm |=> !rail_on ##0 s_down;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate shutdown missed");
endmodule
bind rail_sequencer rail_sequencer_sva #(
    .RETRY_STEP_CYCLES(RETRY_STEP_CYCLES), .IDENT_STRING(IDENT_STRING)
) rail_sequencer_sva_i (
    .core_clk(core_clk), .rstn(rstn), .cmd(cmd), .rsp(rsp), .enable_state(enable_state),
    .own_rail_id(own_rail_id), .turn_off_delay(turn_off_delay),
    .current_share_on(current_share_on), .oc_fault(oc_fault), .clear_faults(clear_faults),
    .bcast_operation_req(bcast_operation_req), .bcast_vout_req(bcast_vout_req),
    .gbus_in(gbus_in), .gbus_out(gbus_out), .rail_on(rail_on), .alert_line_n(alert_line_n),
    .oc_status(oc_status), .operation_hit(operation_hit), .vout_hit(vout_hit)
);
`default_nettype wire

// file: peer_rail_model.sv
// Peer rail controller on the group bus
`default_nettype none
module peer_rail_model (
    input wire logic core_clk,
    input wire rail_seq_pkg::gbus_evt_t from_dut,
    output rail_seq_pkg::gbus_evt_t gbus,
    output logic [2:0] last_kind
);
    initial begin
        gbus = '0;
    end
    always @(posedge core_clk) begin
        if (from_dut.valid) begin
            last_kind <= from_dut.kind;
        end
    end
    task automatic emit(input rail_seq_pkg::evt_kind_t kind, input logic [4:0] id);
        @(negedge core_clk);
        gbus.valid = 1'b1;
        gbus.kind = kind;
        gbus.id = id;
        @(negedge core_clk);
        // Idle bus shows a changed id, never a stale one
        gbus.valid = 1'b0;
        gbus.id = ~id;
    endtask
endmodule
`default_nettype wire

// file: rail_sequencer_tb.sv
// Self-checking bench for the rail sequencing block
`default_nettype none
module rail_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary identifier value
    localparam logic [127:0] IDENT = "TEST-IDENT-ABCD1";
    localparam logic [31:0] GRP = 32'h002C_2926;
    logic core_clk, rstn, enable_state, share, oc_fault, clear_faults, op_req, vout_req;
    logic rail_on, alert_line_n, oc_status, operation_hit, vout_hit;
    logic [2:0] peer_seen;
    logic [127:0] rd;
    rail_seq_pkg::mgmt_cmd_t cmd;
    rail_seq_pkg::mgmt_rsp_t rsp;
    rail_seq_pkg::gbus_evt_t gbus_in, gbus_out;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    int n;
    rail_sequencer #(.RETRY_STEP_CYCLES(10), .IDENT_STRING(IDENT)) rail_sequencer_i (
        .core_clk(core_clk), .rstn(rstn), .cmd(cmd), .rsp(rsp), .enable_state(enable_state),
        .own_rail_id(5'h11), .turn_off_delay(16'h0005), .current_share_on(share),
        .oc_fault(oc_fault), .clear_faults(clear_faults), .bcast_operation_req(op_req),
        .bcast_vout_req(vout_req), .gbus_in(gbus_in), .gbus_out(gbus_out),
        .rail_on(rail_on), .alert_line_n(alert_line_n), .oc_status(oc_status),
        .operation_hit(operation_hit), .vout_hit(vout_hit));
    peer_rail_model peer_rail_model_i (.core_clk(core_clk), .from_dut(gbus_out),
        .gbus(gbus_in), .last_kind(peer_seen));
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [31:0] d,
            input logic err);
        @(negedge core_clk);
        cmd = {1'b1, wr, code, d};
        @(negedge core_clk);
        cmd.valid = 1'b0;
        chk(rsp.valid, 1'b1);
        chk(rsp.error, err);
        rd = rsp.data;
    endtask
    task automatic wait_rail(input logic level);
        n = 0;
        while (rail_on !== level && n < 100) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    task automatic oc_pulse(input logic hold);
        @(negedge core_clk);
        oc_fault = 1'b1;
        @(negedge core_clk);
        oc_fault = hold;
        chk(rail_on, 1'b0);
        chk({alert_line_n, oc_status}, 2'b01);
    endtask
    task automatic t_regs;
        xfer(0, rail_seq_pkg::CODE_RAIL_ORDER, 0, 0);
        chk(rd[15:0], rail_seq_pkg::RAIL_ORDER_RESET);
        xfer(0, rail_seq_pkg::CODE_GROUP, 0, 0);
        chk(rd[31:0], rail_seq_pkg::GROUP_RESET);
        xfer(0, rail_seq_pkg::CODE_OC_ACTION, 0, 0);
        chk(rd[7:0], rail_seq_pkg::OC_ACTION_RESET);
        xfer(0, rail_seq_pkg::CODE_IDENT, 0, 0);
        chk(rd, IDENT);
        xfer(1, rail_seq_pkg::CODE_IDENT, 32'h1234_5678, 1);
        xfer(0, 8'h00_10, 0, 1);
        xfer(1, rail_seq_pkg::CODE_GROUP, GRP, 0);
        xfer(0, rail_seq_pkg::CODE_GROUP, 0, 0);
        chk(rd[31:0], GRP);
        $display("test regs done");
    endtask
    task automatic t_seq;
        xfer(1, rail_seq_pkg::CODE_RAIL_ORDER, 32'h0000_8384, 0);
        enable_state = 1'b1;
        peer_rail_model_i.emit(rail_seq_pkg::EVT_POWER_GOOD, 5'h04);
        repeat (6) @(negedge core_clk);
        chk(rail_on, 1'b0);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_POWER_GOOD, 5'h03);
        wait_rail(1);
        chk(n < 3, 1'b1);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_POWER_DOWN, 5'h05);
        repeat (10) @(negedge core_clk);
        chk(rail_on, 1'b1);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_POWER_DOWN, 5'h04);
        wait_rail(0);
        chk(n, 6);
        @(negedge core_clk);
        chk(peer_seen, rail_seq_pkg::EVT_POWER_DOWN);
        enable_state = 1'b0;
        xfer(1, rail_seq_pkg::CODE_RAIL_ORDER, 0, 0);
        $display("test seq done");
    endtask
    task automatic t_bcast;
        peer_rail_model_i.emit(rail_seq_pkg::EVT_OPERATION, 5'h09);
        chk(operation_hit, 1'b1);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_OPERATION, 5'h08);
        chk(operation_hit, 1'b0);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_VOUT_COMMAND, 5'h0C);
        chk(vout_hit, 1'b1);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_VOUT_COMMAND, 5'h0D);
        chk(vout_hit, 1'b0);
        @(negedge core_clk);
        op_req = 1'b1;
        @(negedge core_clk);
        op_req = 1'b0;
        chk(gbus_out, {1'b1, 3'h4, 5'h09});
        vout_req = 1'b1;
        @(negedge core_clk);
        vout_req = 1'b0;
        chk(gbus_out, {1'b1, 3'h5, 5'h0C});
        $display("test bcast done");
    endtask
    task automatic t_pfail;
        enable_state = 1'b1;
        wait_rail(1);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_POWER_FAIL, 5'h07);
        chk(rail_on, 1'b1);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_POWER_FAIL, 5'h06);
        chk(rail_on, 1'b0);
        xfer(1, rail_seq_pkg::CODE_GROUP, 32'h002C_2906, 0);
        wait_rail(1);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_POWER_FAIL, 5'h06);
        wait_rail(0);
        chk(n, 6);
        wait_rail(1);
        $display("test pfail done");
    endtask
    task automatic t_oc;
        xfer(1, rail_seq_pkg::CODE_OC_ACTION, 32'h0000_0089, 0);
        oc_pulse(0);
        chk(gbus_out, {1'b1, 3'h3, 5'h06});
        wait_rail(1);
        chk(n >= 20 && n <= 25, 1'b1);
        oc_pulse(0);
        repeat (60) @(negedge core_clk);
        chk(rail_on, 1'b0);
        clear_faults = 1'b1;
        @(negedge core_clk);
        clear_faults = 1'b0;
        chk(oc_status, 1'b0);
        wait_rail(1);
        chk(n < 5, 1'b1);
        // Sharing rail in resume mode follows share-fail events of any group
        xfer(1, rail_seq_pkg::CODE_OC_ACTION, 32'h0000_00C0, 0);
        share = 1'b1;
        oc_pulse(1);
        chk(gbus_out.kind, rail_seq_pkg::EVT_SHARE_FAIL);
        repeat (12) @(negedge core_clk);
        chk(rail_on, 1'b0);
        oc_fault = 1'b0;
        wait_rail(1);
        chk(n < 6, 1'b1);
        peer_rail_model_i.emit(rail_seq_pkg::EVT_SHARE_FAIL, 5'h1F);
        wait_rail(0);
        chk(n, 6);
        $display("test oc done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Whole run needs well under two thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        rstn = 1'b0;
        cmd = '0;
        {enable_state, share, oc_fault, clear_faults, op_req, vout_req} = 6'h00;
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        t_regs();
        t_seq();
        t_bcast();
        t_pfail();
        t_oc();
        wrap_up();
    end
endmodule
`default_nettype wire
